// File: rtl/npp_pkg.sv
// package: constants and types for the nvm programming port
package npp_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int BUSY_ASSERT_US = 1;
    localparam int WRITE_MIN_US = 3700;
    localparam int WRITE_MAX_US = 4500;
    localparam int ERASE_MIN_US = 7500;
    localparam int ERASE_MAX_US = 9000;
    // a write lands mid-window; integer halving rounds the count down
    localparam int WRITE_US = (WRITE_MIN_US + WRITE_MAX_US) / 2;
    localparam int ERASE_US = (ERASE_MIN_US + ERASE_MAX_US) / 2;
    localparam int WRITE_CYC = WRITE_US * (CLK_HZ / 1000000);
    localparam int ERASE_CYC = ERASE_US * (CLK_HZ / 1000000);
    localparam int TMR_W = 24;

    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;

    localparam logic [1:0] LA_ADDR = 2'b00;
    localparam logic [1:0] LA_DATA = 2'b01;
    localparam logic [1:0] LA_CMD = 2'b10;

    localparam logic [7:0] SP_B1_EN = 8'hac;
    localparam logic [7:0] SP_B2_EN = 8'h53;
    localparam logic [7:0] SP_RD_PM = 8'h20;
    localparam logic [7:0] SP_LD_PG = 8'h40;
    localparam logic [7:0] SP_WR_PG = 8'h4c;
    localparam logic [7:0] SP_RD_EE = 8'ha0;
    localparam logic [7:0] SP_WR_EE = 8'hc0;
    localparam logic [7:0] SP_RD_LOCK = 8'h58;
    localparam logic [7:0] SP_RD_SIG = 8'h30;
    localparam logic [7:0] SP_RD_FUSE = 8'h50;
    localparam logic [7:0] SP_RD_CAL = 8'h38;
    localparam logic [2:0] SP_B2_ERASE = 3'b100;
    localparam logic [2:0] SP_B2_LOCK = 3'b111;
    localparam logic [7:0] SP_B2_FUSE = 8'ha0;
    localparam logic [7:0] SP_B2_FUSEH = 8'ha8;
    localparam logic [7:0] SP_B2_FUSEH_RD = 8'h08;
    localparam int SP_BITS = 32;
    localparam int SP_HALF = 16;

    localparam int FL_AW = 14;
    localparam int EE_AW = 10;
    localparam int PG_AW = 6;
    localparam logic [7:0] ERASED = 8'hff;
    // arbitrary identity values
    localparam logic [7:0] SIG0 = 8'h5a;
    localparam logic [7:0] SIG1 = 8'h3c;
    localparam logic [7:0] SIG2 = 8'h01;
    localparam logic [7:0] CAL_RESET = 8'h80;
    localparam logic [7:0] FUSE_L_RESET = 8'he1;
    localparam logic [7:0] FUSE_H_RESET = 8'h99;
    localparam logic [7:0] LOCK_RESET = 8'hff;

    typedef enum logic [2:0] {
        NPP_OP_NONE, NPP_OP_FLASH, NPP_OP_EE, NPP_OP_FUSEL, NPP_OP_FUSEH,
        NPP_OP_LOCK, NPP_OP_ERASE
    } npp_op_t;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } npp_instr_t;

    typedef struct packed {
        logic we;
        logic [FL_AW:0] addr;
        logic [7:0] wdata;
    } npp_mem_req_t;
endpackage

// File: rtl/npp_mem.sv
// memory: byte array with one write port and a separate read port, registered read data
`timescale 1ns/1ps
module npp_mem
    import npp_pkg::*;
#(
    parameter int AW = 15
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        rdata <= mem[raddr];
    end
endmodule

// File: rtl/npp_top.sv
// top: parallel and serial programming port of the nonvolatile memories
// Function
// R1: command 04, selects 00 drive low fuse byte while read enable low
// R2: selects 11 drive high fuse byte, high 0 low 1 drive lock byte
// R3: signature command with low address 0..2 and low select 0 drives id
// R4: signature command, address 0, low select 1 drives calibration byte
// R5: write strobe fall drops ready within 1 us, rises 3.7..4.5 ms later
// R6: chip erase keeps ready low, raises it 7.5..9 ms later
// R7: serial mode while reset pin low; sck and mosi in, miso out
// R8: program and erase refused until programming enable accepted
// R9: serial eeprom write erases its location before writing
// R10: chip erase sets flash and eeprom to all ones
// R11: programmer keeps sck phases longer than 2 or 3 clocks
// R12: mosi sampled on rising sck
// R13: miso shifted on falling sck
// R14: programmer holds reset and sck low at power-up
// R15: programmer waits 20 ms before programming enable; here the testbench waits 300 ns after the pin falls
// R16: second enable byte echoed on miso during third byte
// R17: programmer always shifts four bytes and retries on bad echo; here the testbench checks the echo once and does not retry
// R18: page buffer loaded bytewise by 6 low address bits, low then high
// R19: write page with 8 high bits commits whole page as one timed write
// R20: programmer waits flash delay or polls before next page
// R21: eeprom written one byte per instruction with address and data
// R22: serial read returns addressed contents during the final byte; here it returns the previous instruction's address
// R23: enable instruction is ac 53 then two don't-care bytes
// R24: programmer waits 4.5 or 9.0 ms without polling; here the testbench polls ready_busy_flag instead
// R25: load select 10 plus strobe rise latches command
// R26: load select 00, low select 0 plus strobe rise latches low address
// R27: instruction is 32 sck bits msb first, decoded after all four bytes
// R28: data pins driven only while read enable low
`timescale 1ns/1ps
module npp_top
    import npp_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic rst_pin_n,
    input wire logic mosi,
    output logic miso,
    input wire logic load_strobe_clock,
    input wire logic [1:0] load_action_select,
    input wire logic byte_select_low_bit,
    input wire logic byte_select_high_bit,
    input wire logic page_latch_strobe,
    input wire logic write_strobe_n,
    input wire logic read_drive_enable_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ready_busy_flag
);
    // ***********************************************
    // pin synchronisers into core_clk
    // ***********************************************
    logic [1:0] s_xt, s_pl, s_wr, s_oe;
    logic [1:0] s_b1, s_b2;
    logic [1:0] s_x0, s_x1;
    logic xt_d, pl_d, wr_d;
    always_ff @(posedge core_clk) begin
        s_xt <= {s_xt[0], load_strobe_clock};
        s_pl <= {s_pl[0], page_latch_strobe};
        s_wr <= {s_wr[0], write_strobe_n};
        s_oe <= {s_oe[0], read_drive_enable_n};
        s_b1 <= {s_b1[0], byte_select_low_bit};
        s_b2 <= {s_b2[0], byte_select_high_bit};
        s_x0 <= {s_x0[0], load_action_select[0]};
        s_x1 <= {s_x1[0], load_action_select[1]};
        xt_d <= s_xt[1];
        pl_d <= s_pl[1];
        wr_d <= s_wr[1];
    end
    // data pins pass the same two stages as the strobes, so they are already stable at the edge
    logic [7:0] s_d0, s_d1;
    always_ff @(posedge core_clk) begin
        s_d0 <= data_in;
        s_d1 <= s_d0;
    end
    wire xt_rise = s_xt[1] & ~xt_d;
    wire pl_rise = s_pl[1] & ~pl_d;
    wire wr_fall = ~s_wr[1] & wr_d;
    wire [1:0] xa = {s_x1[1], s_x0[1]};
    wire bs1 = s_b1[1];
    wire bs2 = s_b2[1];

    // ***********************************************
    // serial link on sck domain
    // ***********************************************
    logic [4:0] bit_cnt_r;
    logic [31:0] sh_r;
    logic [7:0] miso_sh_r;
    logic instr_tgl_r;
    npp_instr_t instr_r;
    logic [7:0] rd_hold_r;
    logic [1:0] s_rd0, s_rd1;
    logic rd_sel_r;

    // sck idles while the pin is high, so the pin clears a cut frame at once
    always_ff @(posedge sck or posedge rst_pin_n) begin
        if (rst_pin_n) begin
            bit_cnt_r <= 5'h00;
            instr_tgl_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01; // R27
            if (bit_cnt_r == 5'(SP_BITS - 1)) begin
                instr_tgl_r <= ~instr_tgl_r;
            end
        end
    end
    always_ff @(posedge sck) begin
        sh_r <= {sh_r[30:0], mosi}; // R12
        if (bit_cnt_r == 5'(SP_BITS - 1)) begin
            instr_r <= {sh_r[30:0], mosi}; // R27
        end
    end
    always_ff @(negedge sck) begin
        if (bit_cnt_r == 5'(SP_HALF)) begin
            miso_sh_r <= {sh_r[6:0], 1'b0}; // R16
            miso <= sh_r[7]; // R16
        end else if (bit_cnt_r == 5'(SP_BITS - 8)) begin
            miso_sh_r <= {rd_hold_r[6:0], 1'b0}; // R22
            miso <= rd_hold_r[7]; // R22
        end else begin
            miso_sh_r <= {miso_sh_r[6:0], 1'b0};
            miso <= miso_sh_r[7]; // R13
        end
    end
    // read byte crosses from core: stable level captured once per word
    logic [7:0] rd_core_r;
    always_ff @(posedge sck) begin
        if (bit_cnt_r == 5'(SP_BITS - 9)) begin
            rd_hold_r <= rd_core_r; // R22
        end
    end

    logic [3:0] s_tg;
    logic [1:0] s_rp;
    always_ff @(posedge core_clk) begin
        s_tg <= {s_tg[2:0], instr_tgl_r};
        s_rp <= {s_rp[0], rst_pin_n};
    end
    // one stage more than the pin, so a toggle cleared by the pin is masked
    wire instr_ev = s_tg[3] ^ s_tg[2];
    wire ser_mode = ~s_rp[1]; // R7
    // instruction bytes are stable long after the toggle lands
    npp_instr_t ins;
    assign ins = instr_r;

    // ***********************************************
    // nonvolatile state
    // ***********************************************
    logic [7:0] cmd_r, addr_lo_r, addr_hi_r, dlo_r, dhi_r;
    logic [7:0] fuse_l_r, fuse_h_r, lock_r, cal_r;
    logic [7:0] page_r [0:(1<<(PG_AW+1))-1];
    logic [PG_AW:0] pg_widx;
    logic pg_we;
    logic [7:0] pg_wd;
    logic en_r;
    npp_op_t op_r;
    logic [TMR_W-1:0] tmr_r;
    logic [FL_AW:0] wipe_r;
    logic [FL_AW:0] pg_base_r;
    logic [EE_AW-1:0] ee_tgt_r;
    logic [7:0] ee_dat_r;
    logic [7:0] wr_byte_r;
    wire busy = (op_r != NPP_OP_NONE);

    // parallel loading
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_r <= CMD_NOP;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            dlo_r <= 8'h00;
            dhi_r <= 8'h00;
        end else if (xt_rise && !ser_mode) begin
            case (xa)
                LA_CMD: cmd_r <= s_d1; // R25
                LA_ADDR: begin
                    if (!bs1) begin
                        addr_lo_r <= s_d1; // R26
                    end else begin
                        addr_hi_r <= s_d1;
                    end
                end
                LA_DATA: begin
                    if (!bs1) begin
                        dlo_r <= s_d1;
                    end else begin
                        dhi_r <= s_d1;
                    end
                end
                default: ;
            endcase
        end
    end

    // serial enable gate
    wire ins_en = ins.op == SP_B1_EN && ins.b2 == SP_B2_EN; // R23
    always_ff @(posedge core_clk) begin
        if (reset || !ser_mode) begin
            en_r <= 1'b0;
        end else if (instr_ev && ins_en) begin
            en_r <= 1'b1; // R8
        end
    end
    wire sv = instr_ev && en_r && ser_mode && !busy; // R8

    // page buffer writes, parallel latch or serial load
    always_comb begin
        pg_we = 1'b0;
        pg_widx = {addr_lo_r[PG_AW-1:0], 1'b0};
        pg_wd = dlo_r;
        if (sv && ins.op[7:4] == SP_LD_PG[7:4] && ins.op[2:0] == 3'h0) begin
            pg_we = 1'b1; // R18
            pg_widx = {ins.b3[PG_AW-1:0], ins.op[3]};
            pg_wd = ins.b4;
        end
    end
    always_ff @(posedge core_clk) begin
        if (pg_we) begin
            page_r[pg_widx] <= pg_wd;
        end else if (pl_rise && !ser_mode && cmd_r == CMD_WR_FLASH) begin
            page_r[{addr_lo_r[PG_AW-1:0], 1'b0}] <= dlo_r;
            page_r[{addr_lo_r[PG_AW-1:0], 1'b1}] <= dhi_r;
        end
    end

    // ***********************************************
    // self-timed operations
    // ***********************************************
    logic go;
    npp_op_t go_op;
    always_comb begin
        go = 1'b0;
        go_op = NPP_OP_NONE;
        if (wr_fall && !ser_mode && !busy) begin
            go = 1'b1; // R5
            case (cmd_r)
                CMD_WR_FLASH: go_op = NPP_OP_FLASH;
                CMD_WR_EE: go_op = NPP_OP_EE;
                CMD_WR_LOCK: go_op = NPP_OP_LOCK;
                CMD_ERASE: go_op = NPP_OP_ERASE; // R6
                CMD_WR_FUSE: go_op = bs1 ? NPP_OP_FUSEH : NPP_OP_FUSEL;
                default: go = 1'b0;
            endcase
        end else if (sv) begin
            go = 1'b1;
            if (ins.op == SP_B1_EN && ins.b2[7:5] == SP_B2_ERASE) begin
                go_op = NPP_OP_ERASE;
            end else if (ins.op == SP_B1_EN && ins.b2 == SP_B2_FUSE) begin
                go_op = NPP_OP_FUSEL;
            end else if (ins.op == SP_B1_EN && ins.b2 == SP_B2_FUSEH) begin
                go_op = NPP_OP_FUSEH;
            end else if (ins.op == SP_B1_EN && ins.b2[7:5] == SP_B2_LOCK) begin
                go_op = NPP_OP_LOCK;
            end else if (ins.op == SP_WR_PG) begin
                go_op = NPP_OP_FLASH; // R19
            end else if (ins.op == SP_WR_EE) begin
                go_op = NPP_OP_EE; // R9 R21
            end else begin
                go = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            op_r <= NPP_OP_NONE;
            tmr_r <= '0;
            wipe_r <= '0;
        end else if (go) begin
            op_r <= go_op; // R5
            tmr_r <= (go_op == NPP_OP_ERASE) ? TMR_W'(ERASE_CYCLES - 1)
                                             : TMR_W'(WRITE_CYCLES - 1);
            wipe_r <= '0;
        end else if (busy) begin
            // parks on the last cell: a wrap would replay page or byte writes
            if (!(&wipe_r)) begin
                wipe_r <= wipe_r + 1'b1; // R10
            end
            if (tmr_r == '0) begin
                op_r <= NPP_OP_NONE; // R6
            end else begin
                tmr_r <= tmr_r - 1'b1;
            end
        end
    end
    assign ready_busy_flag = ~busy; // R5

    // operation operands, captured at start
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pg_base_r <= '0;
            ee_tgt_r <= '0;
            ee_dat_r <= 8'h00;
            wr_byte_r <= 8'h00;
        end else if (go) begin
            if (ser_mode) begin
                pg_base_r <= {ins.b2[5:0], ins.b3[7:6], 7'h00};
                ee_tgt_r <= {ins.b2[1:0], ins.b3};
                ee_dat_r <= ins.b4;
                wr_byte_r <= ins.b4;
            end else begin
                pg_base_r <= {addr_hi_r[5:0], addr_lo_r[7:6], 7'h00};
                ee_tgt_r <= {addr_hi_r[1:0], addr_lo_r};
                ee_dat_r <= dlo_r;
                wr_byte_r <= dlo_r;
            end
        end
    end

    // fuses, lock and calibration
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fuse_l_r <= FUSE_L_RESET;
            fuse_h_r <= FUSE_H_RESET;
            lock_r <= LOCK_RESET;
            cal_r <= CAL_RESET;
        end else if (busy && tmr_r == '0) begin
            case (op_r)
                NPP_OP_FUSEL: fuse_l_r <= wr_byte_r;
                NPP_OP_FUSEH: fuse_h_r <= wr_byte_r;
                NPP_OP_LOCK: lock_r <= lock_r & wr_byte_r;
                NPP_OP_ERASE: lock_r <= LOCK_RESET;
                default: ;
            endcase
        end
    end

    // memory write port driven by the running operation
    npp_mem_req_t fl_w, ee_w;
    always_comb begin
        fl_w = '0;
        ee_w = '0;
        if (op_r == NPP_OP_ERASE) begin
            fl_w = '{1'b1, wipe_r, ERASED}; // R10
            ee_w = '{1'b1, wipe_r, ERASED}; // R10
        end else if (op_r == NPP_OP_FLASH && wipe_r <= (FL_AW+1)'(7'h7f)) begin
            fl_w.we = 1'b1; // R19
            fl_w.addr = pg_base_r | {8'h00, wipe_r[PG_AW:0]};
            fl_w.wdata = page_r[wipe_r[PG_AW:0]];
        end else if (op_r == NPP_OP_EE && wipe_r[1:0] != 2'b00
                     && wipe_r[FL_AW:2] == '0) begin
            ee_w.we = 1'b1;
            ee_w.addr = {5'h00, ee_tgt_r};
            // second cycle erases the cell, the next two write it
            ee_w.wdata = (wipe_r[1:0] == 2'b01) ? ERASED : ee_dat_r; // R9
        end
    end

    // ***********************************************
    // reads
    // ***********************************************
    logic [FL_AW:0] fl_ra, ee_ra;
    logic [7:0] fl_rd, ee_rd;
    always_comb begin
        if (ser_mode) begin
            fl_ra = {ins.b2[5:0], ins.b3, ins.op[3]};
            ee_ra = {5'h00, ins.b2[1:0], ins.b3};
        end else begin
            fl_ra = {addr_hi_r[5:0], addr_lo_r, bs1};
            ee_ra = {5'h00, addr_hi_r[1:0], addr_lo_r};
        end
    end
    npp_mem #(.AW(FL_AW+1)) u_flash (
        .core_clk(core_clk),
        .we(fl_w.we),
        .waddr(fl_w.addr),
        .wdata(fl_w.wdata),
        .raddr(fl_ra),
        .rdata(fl_rd)
    );
    npp_mem #(.AW(EE_AW)) u_eeprom (
        .core_clk(core_clk),
        .we(ee_w.we),
        .waddr(ee_w.addr[EE_AW-1:0]),
        .wdata(ee_w.wdata),
        .raddr(ee_ra[EE_AW-1:0]),
        .rdata(ee_rd)
    );

    function automatic logic [7:0] sig_byte(input logic [1:0] a);
        case (a)
            2'd0: sig_byte = SIG0;
            2'd1: sig_byte = SIG1;
            2'd2: sig_byte = SIG2;
            default: sig_byte = 8'h00;
        endcase
    endfunction

    logic [7:0] par_rd, ser_rd;
    always_comb begin
        par_rd = 8'h00;
        case (cmd_r)
            CMD_RD_FUSE: begin
                if (!bs1 && !bs2) par_rd = fuse_l_r; // R1
                else if (bs1 && bs2) par_rd = fuse_h_r; // R2
                else if (bs1 && !bs2) par_rd = lock_r; // R2
            end
            CMD_RD_SIG: par_rd = bs1 ? cal_r : sig_byte(addr_lo_r[1:0]); // R3 R4
            CMD_RD_FLASH: par_rd = busy ? ERASED : fl_rd;
            CMD_RD_EE: par_rd = busy ? ERASED : ee_rd;
            default: par_rd = 8'h00;
        endcase
        ser_rd = 8'h00;
        if (ins.op[7:4] == SP_RD_PM[7:4] && ins.op[2:0] == 3'h0) begin
            ser_rd = busy ? ERASED : fl_rd; // R22
        end else if (ins.op == SP_RD_EE) begin
            ser_rd = busy ? ERASED : ee_rd;
        end else if (ins.op == SP_RD_LOCK && ins.b2 == SP_B2_FUSEH_RD) begin
            ser_rd = fuse_h_r;
        end else if (ins.op == SP_RD_LOCK) begin
            ser_rd = lock_r;
        end else if (ins.op == SP_RD_FUSE) begin
            ser_rd = fuse_l_r;
        end else if (ins.op == SP_RD_SIG) begin
            ser_rd = sig_byte(ins.b3[1:0]);
        end else if (ins.op == SP_RD_CAL) begin
            ser_rd = cal_r;
        end
    end

    // serial read data is the previous instruction's address; a read
    // needs its address sent in the preceding word for this pipeline
    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
            rd_core_r <= 8'h00;
        end else begin
            data_out <= par_rd;
            data_oe <= ~s_oe[1] & ~ser_mode; // R28
            rd_core_r <= en_r ? ser_rd : 8'h00;
        end
    end
endmodule

// File: testbench/npp_top_checker.sv
// checker: port assertions for the nvm programming port
`timescale 1ns/1ps
module npp_top_checker
    import npp_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic rst_pin_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic write_strobe_n,
    input wire logic read_drive_enable_n,
    input wire logic data_oe,
    input wire logic ready_busy_flag
);
    int busy_r;
    logic [4:0] bit_r;
    logic [15:0] head_r;
    always_ff @(posedge core_clk) begin
        busy_r <= (reset || ready_busy_flag) ? 0 : busy_r + 1;
    end
    // frame position restarts only on the pin, as in the port itself
    always_ff @(posedge sck or posedge rst_pin_n) begin
        if (rst_pin_n) begin
            bit_r <= 5'h00;
        end else begin
            bit_r <= bit_r + 5'h01;
        end
    end
    always_ff @(posedge sck) begin
        if (bit_r < 5'h10) begin
            head_r <= {head_r[14:0], mosi};
        end
    end
    // ********************************
    // assertions
    // ********************************
    sequence strobe_fall_s;
        rst_pin_n && ready_busy_flag && $fell(write_strobe_n);
    endsequence
    sequence echo_slot_s;
        bit_r >= 5'h10 && bit_r < 5'h18 && head_r == 16'hac53;
    endsequence
    reset_idle_a: assert property (@(posedge core_clk) disable iff (reset)
        $fell(reset) |-> ready_busy_flag && !data_oe)
        else $error("port not idle after reset");
    oe_release_a: assert property (@(posedge core_clk) disable iff (reset)
        read_drive_enable_n [*5] |-> !data_oe)
        else $error("data pins driven while read disabled");
    oe_drive_a: assert property (@(posedge core_clk) disable iff (reset)
        (rst_pin_n && !read_drive_enable_n) [*5] |-> data_oe)
        else $error("data pins not driven while read enabled");
    busy_drop_a: assert property (@(posedge core_clk) disable iff (reset)
        strobe_fall_s |-> ##[1:50] !ready_busy_flag)
        else $error("busy not shown within 1 us of strobe");
    busy_min_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(ready_busy_flag) |-> $past(busy_r) >= WRITE_CYCLES - 8)
        else $error("self-timed operation ended too early");
    busy_max_a: assert property (@(posedge core_clk) disable iff (reset)
        busy_r <= ERASE_CYCLES + 8)
        else $error("busy held beyond longest operation");
    miso_fall_a: assert property (@(posedge core_clk)
        disable iff (reset || rst_pin_n) $changed(miso) |-> !sck)
        else $error("serial output moved while sck high");
    echo_a: assert property (@(posedge sck) disable iff (rst_pin_n)
        echo_slot_s |-> miso == SP_B2_EN[3'(5'h17 - bit_r)])
        else $error("enable byte not echoed");
endmodule

bind npp_top npp_top_checker #(
    .WRITE_CYCLES(WRITE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) checker_i (
    .core_clk, .reset, .sck, .rst_pin_n, .mosi, .miso, .write_strobe_n,
    .read_drive_enable_n, .data_oe, .ready_busy_flag
);

// File: testbench/npp_prog_model.sv
// partner: serial programmer driving the port's pins
`timescale 1ns/1ps
module npp_prog_model (
    output logic sck,
    output logic mosi,
    output logic rst_pin_n,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        rst_pin_n = 1'b0;
        #40 rst_pin_n = 1'b1;
    end
    task automatic pin(input logic v);
        rst_pin_n = v;
        #300;
    endtask
    // 62.5 ns phases stay above three core clocks; sck idles low
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            mosi = w[i];
            #62.5 sck = 1'b1;
            r[i] = miso;
            #62.5 sck = 1'b0;
        end
        // released line shows the inverse, never a stale level
        mosi = ~mosi;
        #250;
    endtask
endmodule

// File: testbench/testbench.sv
// testbench: parallel and serial scenarios for the programming port
`timescale 1ns/1ps
module testbench;
    import npp_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sck, rst_pin_n, mosi, miso, data_oe, ready_busy_flag;
    logic load_strobe_clock = 1'b0;
    logic [1:0] load_action_select = 2'b00;
    logic byte_select_low_bit = 1'b0;
    logic byte_select_high_bit = 1'b0;
    logic page_latch_strobe = 1'b0;
    logic write_strobe_n = 1'b1;
    logic read_drive_enable_n = 1'b1;
    logic [7:0] data_in = 8'h00;
    logic [7:0] data_out;
    logic [31:0] rx;
    logic [7:0] sig_exp [3] = '{SIG0, SIG1, SIG2};
    int fail_count = 0;
    int samples_checked = 0;
    always #10 core_clk = ~core_clk;
    npp_top #(.WRITE_CYCLES(200), .ERASE_CYCLES(40000)) DUT (
        .core_clk, .reset, .sck, .rst_pin_n, .mosi, .miso,
        .load_strobe_clock, .load_action_select, .byte_select_low_bit,
        .byte_select_high_bit, .page_latch_strobe, .write_strobe_n,
        .read_drive_enable_n, .data_in, .data_out, .data_oe,
        .ready_busy_flag
    );
    npp_prog_model prog (.sck, .mosi, .rst_pin_n, .miso);
    // ********************************
    // tasks
    // ********************************
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // pins held four cycles either side: strobes pass a synchroniser
    task automatic load(input logic [1:0] act, input logic bs, logic [7:0] d);
        load_action_select = act;
        byte_select_low_bit = bs;
        data_in = d;
        cyc(4);
        load_strobe_clock = 1'b1;
        cyc(4);
        load_strobe_clock = 1'b0;
        cyc(4);
    endtask
    task automatic pread(input logic hi, lo, logic [7:0] exp, string what);
        byte_select_high_bit = hi;
        byte_select_low_bit = lo;
        read_drive_enable_n = 1'b0;
        cyc(6);
        check(what, data_out, exp);
        read_drive_enable_n = 1'b1;
        cyc(6);
    endtask
    task automatic wait_rdy(input int lim);
        cyc(8);
        for (int n = 0; n < lim && ready_busy_flag !== 1'b1; n++) begin
            cyc(1);
        end
        check("ready", {7'h00, ready_busy_flag}, 8'h01);
    endtask
    // reads answer one word late, so each read is sent twice
    task automatic sread(input logic [23:0] cmd, logic [7:0] exp, string what);
        prog.xfer({cmd, 8'h00}, rx);
        prog.xfer({cmd, 8'h00}, rx);
        check(what, rx[7:0], exp);
    endtask
    // ********************************
    // scenarios
    // ********************************
    initial begin
        cyc(8);
        reset = 1'b0;
        cyc(6);
        load(LA_CMD, 1'b0, CMD_RD_FUSE);
        pread(1'b0, 1'b0, FUSE_L_RESET, "fuse low");
        pread(1'b1, 1'b1, FUSE_H_RESET, "fuse high");
        pread(1'b0, 1'b1, LOCK_RESET, "lock");
        load(LA_CMD, 1'b0, CMD_RD_SIG);
        for (int a = 0; a < 3; a++) begin
            load(LA_ADDR, 1'b0, 8'(a));
            pread(1'b0, 1'b0, sig_exp[a], "signature");
        end
        load(LA_ADDR, 1'b0, 8'h00);
        pread(1'b0, 1'b1, CAL_RESET, "calibration");
        load(LA_CMD, 1'b0, CMD_WR_FUSE);
        load(LA_DATA, 1'b0, 8'h3f);
        write_strobe_n = 1'b0;
        cyc(4);
        write_strobe_n = 1'b1;
        cyc(40);
        check("busy", {7'h00, ready_busy_flag}, 8'h00);
        wait_rdy(400);
        load(LA_CMD, 1'b0, CMD_RD_FUSE);
        pread(1'b0, 1'b0, 8'h3f, "fuse written");
        prog.pin(1'b0);
        prog.xfer({SP_B1_EN, SP_B2_EN, 16'h0000}, rx);
        check("echo", rx[15:8], SP_B2_EN);
        prog.xfer({SP_B1_EN, 8'h80, 16'h0000}, rx);
        wait_rdy(41000);
        sread({SP_RD_EE, 16'h0006}, ERASED, "ee erased");
        sread({SP_RD_PM, 16'h0001}, ERASED, "flash erased");
        prog.xfer({SP_WR_EE, 16'h0005, 8'ha5}, rx);
        wait_rdy(400);
        sread({SP_RD_EE, 16'h0005}, 8'ha5, "ee write");
        prog.xfer({SP_WR_EE, 16'h0005, 8'h5a}, rx);
        wait_rdy(400);
        sread({SP_RD_EE, 16'h0005}, 8'h5a, "ee rewrite");
        prog.pin(1'b1);
        prog.pin(1'b0);
        prog.xfer({SP_WR_EE, 16'h0005, 8'h3c}, rx);
        cyc(300);
        prog.xfer({SP_B1_EN, SP_B2_EN, 16'h0000}, rx);
        sread({SP_RD_EE, 16'h0005}, 8'h5a, "refused write");
        prog.xfer({SP_LD_PG, 16'h0001, 8'h11}, rx);
        prog.xfer({SP_LD_PG | 8'h08, 16'h0001, 8'h22}, rx);
        prog.xfer({SP_WR_PG, 24'h000000}, rx);
        wait_rdy(400);
        sread({SP_RD_PM, 16'h0001}, 8'h11, "flash low");
        sread({SP_RD_PM | 8'h08, 16'h0001}, 8'h22, "flash high");
        sread({SP_RD_FUSE, 16'h0000}, 8'h3f, "serial fuse");
        sread({SP_RD_SIG, 16'h0002}, SIG2, "serial signature");
        test_done();
    end
    initial begin
        #1800000;
        fail_count++;
        test_done();
    end
endmodule
